/* File: nva_access_ctrl.sv */
`timescale 1ns/1ns
module nva_access_ctrl import nva_pkg::*; #(
  parameter int unsigned WR_RC_CYCLES = NVA_WR_RC_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Register port
  input wire nva_bus_t regBus,
  output logic [NVA_DATA_W-1:0] regRdata,
  // CPU side
  input wire logic cpuIntEnable,
  input wire logic selfProgramActive,
  output logic cpuStall,
  output logic irq,
  // Array side
  input wire logic rcOsc,
  input wire logic [NVA_DATA_W-1:0] arrRdata,
  output nva_array_t arrayIf
);

  // ****************************************
  // State
  // ****************************************
  nva_op_t opState_q;
  nva_op_t opState_d;
  nva_array_t arrayIf_q;
  nva_array_t arrayIf_d;
  logic readyIrqEnable_q;
  logic [NVA_ADDR_W-1:0] nvAddress_q;
  logic [NVA_DATA_W-1:0] nvData_q;
  logic [NVA_ST_W-1:0] status_q;
  logic [NVA_ST_W-1:0] status_d;
  logic [NVA_ST_W-1:0] mask_q;
  logic [NVA_DATA_W-1:0] rdata_q;
  logic [2:0] stallCnt_q;
  logic [2:0] stallCnt_d;
  logic cpuStall_q;
  logic irq_q;
  logic irq_d;

  // ****************************************
  // Address decode
  // ****************************************
  wire selCtrl = (regBus.addr == NVA_OFF_CTRL);
  wire selAddrLo = (regBus.addr == NVA_OFF_ADDR_LO);
  wire selAddrHi = (regBus.addr == NVA_OFF_ADDR_HI);
  wire selData = (regBus.addr == NVA_OFF_DATA);
  wire selStatus = (regBus.addr == NVA_OFF_STATUS);
  wire selMask = (regBus.addr == NVA_OFF_MASK);
  wire ctrlWr = regBus.wr & selCtrl;

  // ****************************************
  // Sub-blocks
  // ****************************************
  wire armStart = ctrlWr & regBus.wdata[NVA_BIT_ARM];
  logic armed;
  logic busy;
  logic timerDone;

  nva_arm_window u_arm (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(armStart),
    .armed(armed)
  );

  // ****************************************
  // Access start conditions
  // ****************************************
  wire opIdle = (opState_q == NVA_OP_IDLE);
  wire writeReq = ctrlWr & regBus.wdata[NVA_BIT_WRITE];
  // Arm checked as it stood before this write; arm and strobe together fail unless the window is already open
  wire writeStart = writeReq & armed & ~busy & opIdle
                    & ~selfProgramActive;
  wire armFail = writeReq & ~armed;
  // A strobe write wins over a read in the same control write
  wire readStart = ctrlWr & regBus.wdata[NVA_BIT_READ] & ~busy
                   & opIdle & ~writeReq;
  wire addrLoWr = regBus.wr & selAddrLo & ~busy;
  wire addrHiWr = regBus.wr & selAddrHi & ~busy;
  wire dataWr = regBus.wr & selData;
  wire statusRd = regBus.rd & selStatus;
  wire readCapture = (opState_q == NVA_OP_READ);

  nva_write_timer #(
    .CYCLES(WR_RC_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rcOsc(rcOsc),
    .start(writeStart),
    .busy(busy),
    .done(timerDone)
  );

  // ****************************************
  // Operation sequencing
  // ****************************************
  always_comb begin
    opState_d = opState_q;
    unique case (opState_q)
      NVA_OP_IDLE: begin
        if (writeStart) begin
          opState_d = NVA_OP_WRITE;
        end else if (readStart) begin
          opState_d = NVA_OP_READ;
        end
      end
      NVA_OP_READ: begin
        opState_d = NVA_OP_IDLE;
      end
      NVA_OP_WRITE: begin
        if (timerDone) begin
          opState_d = NVA_OP_IDLE;
        end
      end
      default: begin
        opState_d = NVA_OP_IDLE;
      end
    endcase
  end

  // Array sees a latched copy so software may reload the data register during a write
  always_comb begin
    arrayIf_d = arrayIf_q;
    arrayIf_d.wr = (opState_d == NVA_OP_WRITE);
    arrayIf_d.rd = (opState_d == NVA_OP_READ);
    if (writeStart || readStart) begin
      arrayIf_d.addr = nvAddress_q;
    end
    if (writeStart) begin
      arrayIf_d.data = nvData_q;
    end
  end

  // ****************************************
  // CPU stall
  // ****************************************
  assign stallCnt_d = writeStart ? NVA_WR_STALL :
                      readStart ? NVA_RD_STALL :
                      (stallCnt_q != 3'h0) ? stallCnt_q - 3'h1 : 3'h0;

  // ****************************************
  // Interrupt
  // ****************************************
  // Set wins over the clear-on-read
  assign status_d = (statusRd ? NVA_ST_RST : status_q)
                    | {armFail, readCapture, timerDone};
  // Ready level stays up for as long as no write is running
  assign irq_d = (readyIrqEnable_q & cpuIntEnable & ~busy)
                 | (|(status_q & mask_q));

  // ****************************************
  // Read selection
  // ****************************************
  wire [NVA_DATA_W-1:0] ctrlView = {4'h0, readyIrqEnable_q, armed,
                                    busy, 1'b0};
  wire [NVA_DATA_W-1:0] rdMux =
    selCtrl ? ctrlView :
    selAddrLo ? nvAddress_q[7:0] :
    selAddrHi ? {6'h00, nvAddress_q[9:8]} :
    selData ? nvData_q :
    selStatus ? {5'h00, status_q} :
    selMask ? {5'h00, mask_q} : 8'h00;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      opState_q <= NVA_OP_IDLE;
      arrayIf_q <= '0;
      stallCnt_q <= 3'h0;
      cpuStall_q <= 1'b0;
    end else if (ce) begin
      opState_q <= opState_d;
      arrayIf_q <= arrayIf_d;
      stallCnt_q <= stallCnt_d;
      cpuStall_q <= (stallCnt_d != 3'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readyIrqEnable_q <= 1'b0;
      nvAddress_q <= NVA_ADDR_RST;
      mask_q <= NVA_ST_RST;
    end else if (ce) begin
      if (ctrlWr) begin
        readyIrqEnable_q <= regBus.wdata[NVA_BIT_RIE];
      end
      if (addrLoWr) begin
        nvAddress_q[7:0] <= regBus.wdata;
      end
      if (addrHiWr) begin
        nvAddress_q[9:8] <= regBus.wdata[1:0];
      end
      if (regBus.wr && selMask) begin
        mask_q <= regBus.wdata[NVA_ST_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      nvData_q <= NVA_DATA_RST;
      status_q <= NVA_ST_RST;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else if (ce) begin
      if (readCapture) begin
        nvData_q <= arrRdata;
      end else if (dataWr) begin
        nvData_q <= regBus.wdata;
      end
      status_q <= status_d;
      rdata_q <= regBus.rd ? rdMux : 8'h00;
      irq_q <= irq_d;
    end
  end

  assign regRdata = rdata_q;
  assign cpuStall = cpuStall_q;
  assign irq = irq_q;
  assign arrayIf = arrayIf_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_reserved_zero:
  assert property (@(posedge clk) disable iff (rst || !ce)
    (regBus.rd && selCtrl) |=> (regRdata[7:4] == 4'h0))
    else $error("reserved control bits read nonzero");

  a_strobe_readback:
  assert property (@(posedge clk) disable iff (rst || !ce)
    (regBus.rd && selCtrl) |=> (regRdata[1] == $past(busy)))
    else $error("write strobe bit does not show busy");

  a_ready_level:
  assert property (@(posedge clk) disable iff (rst || !ce)
    (readyIrqEnable_q && cpuIntEnable && !busy) [*2] |-> irq)
    else $error("ready interrupt not held while idle");

  a_ready_gated:
  assert property (@(posedge clk) disable iff (rst || !ce)
    (!(readyIrqEnable_q && cpuIntEnable) && !(|(status_q & mask_q))) [*2]
    |-> !irq)
    else $error("interrupt raised while disabled");

  a_write_armed:
  assert property (@(posedge clk) disable iff (rst || !ce)
    writeStart |-> ($past(armStart, 1) || $past(armStart, 2) ||
                    $past(armStart, 3) || $past(armStart, 4)))
    else $error("write started without arm");

  a_no_spm_write:
  assert property (@(posedge clk) disable iff (rst || !ce)
    (opState_q == NVA_OP_IDLE && selfProgramActive) |=> !arrayIf.wr)
    else $error("array write during self-programming");

  a_write_stall:
  assert property (@(posedge clk) disable iff (rst || !ce)
    writeStart |=> cpuStall [*2] ##1 !cpuStall)
    else $error("write stall not two cycles");

  a_read_stall:
  assert property (@(posedge clk) disable iff (rst || !ce)
    readStart |=> cpuStall [*4])
    else $error("read stall not four cycles");

  a_addr_frozen:
  assert property (@(posedge clk) disable iff (rst || !ce)
    busy |=> $stable(nvAddress_q))
    else $error("address changed during write");

  a_array_hold:
  assert property (@(posedge clk) disable iff (rst || !ce)
    arrayIf.wr |=> (!arrayIf.wr ||
                    ($stable(arrayIf.addr) && $stable(arrayIf.data))))
    else $error("array address or data moved during write");

  a_read_data:
  assert property (@(posedge clk) disable iff (rst || !ce)
    readStart |=> arrayIf.rd ##1 (nvData_q == $past(arrRdata)))
    else $error("read byte not captured in data register");

endmodule

/* File: nva_arm_window.sv */
`timescale 1ns/1ns
module nva_arm_window import nva_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic start,
  output logic armed
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // Rewriting the arm bit restarts the window
  assign cnt_d = start ? NVA_ARM_CYCLES :
                 (cnt_q != 3'h0) ? cnt_q - 3'h1 : 3'h0;
  assign armed = (cnt_q != 3'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 3'h0;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end

  a_arm_open:
  assert property (@(posedge clk) disable iff (rst || !ce)
    start |=> armed [*4])
    else $error("arm window shorter than four cycles");

  a_arm_expire:
  assert property (@(posedge clk) disable iff (rst || !ce)
    start ##1 (!start) [*4] |=> !armed)
    else $error("arm bit not cleared after four cycles");

endmodule

/* File: nva_array_model.sv */
`timescale 1ns/1ns
module nva_array_model import nva_pkg::*; (
  // Clock
  input wire logic clk,
  // Array side
  input wire nva_array_t arrayIf,
  output logic rcOsc,
  output logic [NVA_DATA_W-1:0] arrRdata
);
  logic [NVA_DATA_W-1:0] mem [0:1023];
  nva_array_t held;
  logic wrPrev;

  // ****************************************
  // Timing oscillator
  // ****************************************
  // Free running, phase unrelated to clk
  initial begin
    rcOsc = 1'b0;
    #3;
    forever #35 rcOsc = ~rcOsc;
  end

  // ****************************************
  // Byte store
  // ****************************************
  initial begin
    wrPrev = 1'b0;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'(i) ^ 8'h3c;
    end
  end

  // Commit on completion, using what was presented at the start
  always @(posedge clk) begin
    if (arrayIf.wr && !wrPrev) begin
      held <= arrayIf;
    end
    if (!arrayIf.wr && wrPrev) begin
      mem[held.addr] <= held.data;
    end
    wrPrev <= arrayIf.wr;
  end

  // Outside a read strobe the byte lines show no stale value
  assign arrRdata = arrayIf.rd ? mem[arrayIf.addr] : ~mem[arrayIf.addr];
endmodule

/* File: nva_pkg.sv */
package nva_pkg;

  // ****************************************
  // Register offsets on the register port
  // ****************************************
  localparam int NVA_REG_AW = 3;
  localparam logic [2:0] NVA_OFF_CTRL = 3'h0;
  localparam logic [2:0] NVA_OFF_ADDR_LO = 3'h1;
  localparam logic [2:0] NVA_OFF_ADDR_HI = 3'h2;
  localparam logic [2:0] NVA_OFF_DATA = 3'h3;
  localparam logic [2:0] NVA_OFF_STATUS = 3'h4;
  localparam logic [2:0] NVA_OFF_MASK = 3'h5;

  // ****************************************
  // Field positions and widths
  // ****************************************
  localparam int NVA_DATA_W = 8;
  localparam int NVA_ADDR_W = 10;
  localparam int NVA_BIT_READ = 0;
  localparam int NVA_BIT_WRITE = 1;
  localparam int NVA_BIT_ARM = 2;
  localparam int NVA_BIT_RIE = 3;
  localparam int NVA_ST_W = 3;
  localparam int NVA_ST_WRDONE = 0;
  localparam int NVA_ST_RDDONE = 1;
  localparam int NVA_ST_ARMFAIL = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] NVA_DATA_RST = 8'h00;
  localparam logic [9:0] NVA_ADDR_RST = 10'h000;
  localparam logic [2:0] NVA_ST_RST = 3'h0;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [2:0] NVA_ARM_CYCLES = 3'h4;
  localparam logic [2:0] NVA_WR_STALL = 3'h2;
  localparam logic [2:0] NVA_RD_STALL = 3'h4;
  localparam int NVA_WR_CNT_W = 15;
  localparam int unsigned NVA_WR_RC_CYCLES = 27072;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    NVA_OP_IDLE = 2'b00,
    NVA_OP_READ = 2'b01,
    NVA_OP_WRITE = 2'b10
  } nva_op_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [NVA_ADDR_W-1:0] addr;
    logic [NVA_DATA_W-1:0] data;
  } nva_array_t;

  typedef struct packed {
    logic [NVA_REG_AW-1:0] addr;
    logic [NVA_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } nva_bus_t;

endpackage

/* File: nva_write_timer.sv */
`timescale 1ns/1ns
module nva_write_timer import nva_pkg::*; #(
  parameter int unsigned CYCLES = NVA_WR_RC_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Oscillator pin
  input wire logic rcOsc,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);

  localparam logic [NVA_WR_CNT_W-1:0] LAST = NVA_WR_CNT_W'(CYCLES - 1);

  logic rcSync1_q;
  logic rcSync2_q;
  logic rcSync3_q;
  logic busy_q;
  logic [NVA_WR_CNT_W-1:0] cnt_q;
  logic rcEdge;

  // Edge taken past the synchroniser only
  assign rcEdge = rcSync2_q & ~rcSync3_q;
  assign done = busy_q & rcEdge & (cnt_q == LAST);
  assign busy = busy_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rcSync1_q <= 1'b0;
      rcSync2_q <= 1'b0;
      rcSync3_q <= 1'b0;
    end else if (ce) begin
      rcSync1_q <= rcOsc;
      rcSync2_q <= rcSync1_q;
      rcSync3_q <= rcSync2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (ce) begin
      if (start) begin
        busy_q <= 1'b1;
        cnt_q <= '0;
      end else if (done) begin
        busy_q <= 1'b0;
      end else if (busy_q && rcEdge) begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  a_timer_length:
  assert property (@(posedge clk) disable iff (rst || !ce)
    (busy_q && rcEdge && cnt_q != LAST) |=> busy_q)
    else $error("write ended before the oscillator count");

  a_timer_release:
  assert property (@(posedge clk) disable iff (rst || !ce)
    done |=> !busy_q)
    else $error("busy not released after write time");

endmodule

/* File: test_nva_access_ctrl.sv */
`timescale 1ns/1ns
module test_nva_access_ctrl import nva_pkg::*; ;
  localparam int unsigned WR_CYC = 4;
  logic clk, rst, ce, cpuIntEnable, selfProgramActive;
  logic cpuStall, irq, rcOsc;
  logic [NVA_DATA_W-1:0] regRdata, arrRdata;
  nva_bus_t regBus;
  nva_array_t arrayIf;
  int nFail, nTests, stallCnt, wrCnt;

  nva_access_ctrl #(.WR_RC_CYCLES(WR_CYC)) i_nva_access_ctrl (
    .clk(clk), .rst(rst), .ce(ce), .regBus(regBus), .regRdata(regRdata),
    .cpuIntEnable(cpuIntEnable), .selfProgramActive(selfProgramActive),
    .cpuStall(cpuStall), .irq(irq), .rcOsc(rcOsc), .arrRdata(arrRdata),
    .arrayIf(arrayIf)
  );
  nva_array_model i_nva_array_model (
    .clk(clk), .arrayIf(arrayIf), .rcOsc(rcOsc), .arrRdata(arrRdata)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (cpuStall === 1'b1) stallCnt++;
    if (arrayIf.wr === 1'b1) wrCnt++;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    nTests++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic regWr(input logic [2:0] a, input logic [7:0] d);
    regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regBus.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic regRd(input logic [2:0] a, input logic [7:0] exp);
    regBus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regBus.rd <= 1'b0;
    #1;
    check(regRdata, exp);
    @(posedge clk);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chkIrq(input logic e);
    @(posedge clk);
    #1;
    check(irq, e);
    @(posedge clk);
  endtask

  task automatic waitIdle();
    int k;
    k = 0;
    while (arrayIf.wr !== 1'b0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    check({23'h0, k < 200}, 24'h1);
    // Array commits on the edge after its write level drops
    @(posedge clk);
  endtask

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testRegs();
    regRd(NVA_OFF_CTRL, 8'h00);
    regRd(NVA_OFF_DATA, 8'h00);
    regWr(NVA_OFF_CTRL, 8'hf0);
    regRd(NVA_OFF_CTRL, 8'h00);
    regWr(3'h7, 8'h5a);
    regRd(3'h7, 8'h00);
    regRd(3'h6, 8'h00);
    $display("test registers done");
  endtask

  task automatic testWrite();
    regWr(NVA_OFF_ADDR_LO, 8'ha5);
    regWr(NVA_OFF_ADDR_HI, 8'h02);
    regWr(NVA_OFF_DATA, 8'h5c);
    stallCnt = 0;
    wrCnt = 0;
    regWr(NVA_OFF_CTRL, 8'h04);
    // Strobe lands on the last cycle of the arm window
    waitCyc(2);
    regWr(NVA_OFF_CTRL, 8'h02);
    regRd(NVA_OFF_CTRL, 8'h02);
    check(arrayIf, {1'b1, 1'b0, 10'h2a5, 8'h5c});
    regWr(NVA_OFF_ADDR_LO, 8'h11);
    regWr(NVA_OFF_CTRL, 8'h01);
    check(arrayIf, {1'b1, 1'b0, 10'h2a5, 8'h5c});
    check(stallCnt, 24'h2);
    waitIdle();
    check({23'h0, wrCnt >= 21 && wrCnt <= 36}, 24'h1);
    check(i_nva_array_model.mem[10'h2a5], 8'h5c);
    regRd(NVA_OFF_CTRL, 8'h00);
    regRd(NVA_OFF_STATUS, 8'h01);
    regRd(NVA_OFF_STATUS, 8'h00);
    $display("test write done");
  endtask

  task automatic testRead();
    stallCnt = 0;
    regWr(NVA_OFF_CTRL, 8'h01);
    waitCyc(4);
    check(stallCnt, 24'h4);
    regRd(NVA_OFF_DATA, 8'h5c);
    regRd(NVA_OFF_STATUS, 8'h02);
    regWr(NVA_OFF_ADDR_HI, 8'h03);
    regWr(NVA_OFF_ADDR_LO, 8'hff);
    regWr(NVA_OFF_CTRL, 8'h01);
    regRd(NVA_OFF_DATA, 8'hc3);
    regRd(NVA_OFF_STATUS, 8'h02);
    $display("test read done");
  endtask

  task automatic testArm();
    wrCnt = 0;
    regWr(NVA_OFF_CTRL, 8'h04);
    regRd(NVA_OFF_CTRL, 8'h04);
    // One cycle past the window
    waitCyc(1);
    regWr(NVA_OFF_CTRL, 8'h02);
    regRd(NVA_OFF_CTRL, 8'h00);
    regRd(NVA_OFF_STATUS, 8'h04);
    regWr(NVA_OFF_CTRL, 8'h06);
    regRd(NVA_OFF_STATUS, 8'h04);
    waitCyc(4);
    check(wrCnt, 24'h0);
    $display("test arm window done");
  endtask

  task automatic testSelfProgram();
    wrCnt = 0;
    selfProgramActive <= 1'b1;
    regWr(NVA_OFF_CTRL, 8'h04);
    regWr(NVA_OFF_CTRL, 8'h02);
    regRd(NVA_OFF_STATUS, 8'h00);
    check(wrCnt, 24'h0);
    selfProgramActive <= 1'b0;
    waitCyc(4);
    $display("test self program done");
  endtask

  task automatic testIrq();
    regWr(NVA_OFF_CTRL, 8'h08);
    chkIrq(1'b0);
    cpuIntEnable <= 1'b1;
    chkIrq(1'b1);
    waitCyc(5);
    chkIrq(1'b1);
    regWr(NVA_OFF_CTRL, 8'h0c);
    regWr(NVA_OFF_CTRL, 8'h0a);
    chkIrq(1'b0);
    waitIdle();
    chkIrq(1'b1);
    regRd(NVA_OFF_STATUS, 8'h01);
    regWr(NVA_OFF_CTRL, 8'h00);
    chkIrq(1'b0);
    regWr(NVA_OFF_MASK, 8'h02);
    regRd(NVA_OFF_MASK, 8'h02);
    regWr(NVA_OFF_CTRL, 8'h01);
    chkIrq(1'b1);
    regRd(NVA_OFF_STATUS, 8'h02);
    chkIrq(1'b0);
    cpuIntEnable <= 1'b0;
    $display("test interrupt done");
  endtask

  task automatic testFreeze();
    // Low enable must drop a register write and hold the outputs
    ce <= 1'b0;
    regWr(NVA_OFF_MASK, 8'h05);
    check(irq, 1'b0);
    ce <= 1'b1;
    regRd(NVA_OFF_MASK, 8'h02);
    $display("test clock enable done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cpuIntEnable = 1'b0;
    selfProgramActive = 1'b0;
    regBus = '0;
    nFail = 0;
    nTests = 0;
    stallCnt = 0;
    wrCnt = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    testRegs();
    testWrite();
    testRead();
    testArm();
    testSelfProgram();
    testIrq();
    testFreeze();
    giveVerdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    nFail++;
    giveVerdict();
  end
endmodule
